//--- core/rtam_map.svh
// Constants of the temperature alarm monitor: offsets, resets, timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef RTAM_MAP_SVH
`define RTAM_MAP_SVH
// ****************************************
// Bus addresses and pointer offsets
// ****************************************
`define RTAM_ARA_ADDR 7'h0C
`define RTAM_PTR_LOC 8'h00
`define RTAM_PTR_REM_HI 8'h01
`define RTAM_PTR_REM_LO 8'h02
`define RTAM_PTR_STATUS 8'h03
`define RTAM_PTR_LIM 8'h04
`define RTAM_RD_UNMAPPED 8'h00
// ****************************************
// Status byte bit positions
// ****************************************
`define RTAM_ST_LOC_HI 0
`define RTAM_ST_LOC_LO 1
`define RTAM_ST_LOC_CR 2
`define RTAM_ST_REM_HI 3
`define RTAM_ST_REM_LO 4
`define RTAM_ST_REM_CR 5
// ****************************************
// Limit reset values, whole degrees
// ****************************************
`define RTAM_HI_RST 8'h46
`define RTAM_LO_RST 8'h00
`define RTAM_LOC_CR_RST 8'h55
`define RTAM_REM_CR_RST 8'h6E
// ****************************************
// Remote shift and timing
// ****************************************
`define RTAM_REM_SHIFT_C 16
`define RTAM_REM_SHIFT_Q 13'h080
`define RTAM_TOUT_MS 25
`define RTAM_CLK_MHZ 100
`endif

//--- core/rtam_pkg.sv
// Types shared by the temperature alarm monitor design files.
// Assumes rtam_map.svh is on the include path.
package rtam_pkg;
  `include "rtam_map.svh"
  // Bus slave sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK
  } rtam_smb_state_type;
  // Remote reading in eighths of a degree, two's complement
  typedef logic signed [10:0] rtam_rem_type;
endpackage

//--- core/rtam_conv_link.sv
// Crossing of converter results from the converter clock into clk.
// Assumes samples are spaced far more than four clk cycles apart.
`timescale 1ns/100ps
module rtam_conv_link import rtam_pkg::*; (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, clk domain
  input wire logic conv_clk, // Converter clock
  input wire logic conv_valid, // New sample pulse, conv_clk domain
  input wire logic [7:0] conv_loc, // Local degrees, signed
  input wire logic [11:0] conv_rem, // Remote junction, eighths, signed
  output logic new_pulse, // One-cycle pulse with fresh data
  output logic [7:0] loc, // Local sample, clk domain
  output logic [11:0] rem // Remote sample, clk domain
);
  // ****************************************
  // Converter domain
  // ****************************************
  logic [1:0] crst_s;
  logic tog;
  logic [7:0] hold_loc;
  logic [11:0] hold_rem;
  logic [2:0] tog_s;
  logic seen;

  // Reset carried into the converter domain
  always_ff @(posedge conv_clk) begin
    crst_s <= {crst_s[0], rst};
  end

  // Hold each sample and flag it by a toggle
  always_ff @(posedge conv_clk) begin
    if (crst_s[1]) begin
      tog <= 1'b0;
      hold_loc <= 8'h00;
      hold_rem <= 12'h000;
    end else if (conv_valid) begin
      tog <= ~tog;
      hold_loc <= conv_loc;
      hold_rem <= conv_rem;
    end
  end

  // ****************************************
  // System domain
  // ****************************************
  // Toggle synchroniser, edge seen on the later stages
  assign seen = tog_s[1] ^ tog_s[2];

  always_ff @(posedge clk) begin
    if (rst) begin
      tog_s <= 3'h0;
      new_pulse <= 1'b0;
      loc <= 8'h00;
      rem <= 12'h000;
    end else begin
      tog_s <= {tog_s[1:0], tog};
      new_pulse <= seen;
      if (seen) begin
        loc <= hold_loc;
        rem <= hold_rem;
      end
    end
  end
endmodule // rtam_conv_link

//--- core/rtam_core.sv
// Temperature alarm monitor: bus slave, limits, comparators, alarms.
// Assumes open-drain pins resolved outside, pull-ups on every line.
`timescale 1ns/100ps
`include "rtam_map.svh"
module rtam_core import rtam_pkg::*; #(
  // Arbitrary default; the second variant takes a different value
  parameter logic [6:0] SLAVE_ADDR = 7'h2A,
  parameter int TOUT_CYC = `RTAM_TOUT_MS * 1000 * `RTAM_CLK_MHZ,
  parameter int TOUT_W = 22
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic conv_clk, // Converter clock
  input wire logic conv_valid, // Converter sample strobe
  input wire logic [7:0] conv_loc, // Local degrees, signed
  input wire logic [11:0] conv_rem, // Remote junction, eighths
  input wire logic scl_i, // Bus clock pin level
  input wire logic sda_i, // Bus data pin level
  output logic sda_o, // Bus data drive value, always low
  output logic sda_oe, // Bus data pull-down enable
  output logic alert_o, // Alert drive value, always low
  output logic alert_oe, // Alert pull-down enable
  output logic critical_alarm_out, // Critical drive value, low
  output logic critical_alarm_oe // Critical pull-down enable
);
  localparam int NLIM = 6;
  // ****************************************
  // Parameter checks
  // ****************************************
  if (TOUT_CYC < 2 || TOUT_CYC >= 2 ** TOUT_W ||
      SLAVE_ADDR == `RTAM_ARA_ADDR) begin : g_bad
    $error("rtam_core: bad timeout or slave address");
  end

  // ****************************************
  // Declarations
  // ****************************************
  rtam_smb_state_type state;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [TOUT_W-1:0] tout_cnt;
  logic [3:0] bit_cnt;
  logic [7:0] sh;
  logic [7:0] tx_sh;
  logic [7:0] ptr;
  logic rw;
  logic first;
  logic ack_on;
  logic ara;
  logic armed;
  logic [7:0] loc_val;
  rtam_rem_type rem_val;
  logic link_new;
  logic [7:0] link_loc;
  logic [11:0] link_rem;
  logic [7:0] lim_w [NLIM];
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic tout_hit;
  logic [7:0] rx_byte;
  logic last_bit;
  logic me;
  logic ara_hit;
  logic lost;
  logic ara_done;
  logic wr_stb;
  logic [7:0] status;
  logic [7:0] rd_reg;
  logic [7:0] rd_byte;
  logic signed [12:0] rem_diff;
  logic rem_ovf;
  rtam_rem_type rem_sat;
  logic loc_hi;
  logic loc_lo;
  logic loc_cr;
  logic rem_hi;
  logic rem_lo;
  logic rem_cr;
  logic crit_any;
  logic out_win;

  // ****************************************
  // Converter crossing
  // ****************************************
  rtam_conv_link u_link (
    .clk(clk),
    .rst(rst),
    .conv_clk(conv_clk),
    .conv_valid(conv_valid),
    .conv_loc(conv_loc),
    .conv_rem(conv_rem),
    .new_pulse(link_new),
    .loc(link_loc),
    .rem(link_rem)
  );

  // Remote shifted down and clamped to eleven bits
  assign rem_diff = $signed({link_rem[11], link_rem}) -
                    $signed(`RTAM_REM_SHIFT_Q);
  assign rem_ovf = (rem_diff[12:10] != 3'h0) && (rem_diff[12:10] != 3'h7);
  assign rem_sat = rem_ovf ? (rem_diff[12] ? 11'h400 : 11'h3FF)
                           : rem_diff[10:0];

  // Latest readings
  always_ff @(posedge clk) begin
    if (rst) begin
      loc_val <= 8'h00;
      rem_val <= 11'h000;
    end else if (link_new) begin
      loc_val <= link_loc;
      rem_val <= rem_sat;
    end
  end

  // ****************************************
  // Pin synchronisers and bus events
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
    end
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  assign tout_hit = tout_cnt == TOUT_W'(TOUT_CYC - 1);

  // Clock-low timer for the bus timeout
  always_ff @(posedge clk) begin
    if (rst || scl_s[1]) begin
      tout_cnt <= '0;
    end else if (!tout_hit) begin
      tout_cnt <= tout_cnt + 1'b1;
    end
  end

  // ****************************************
  // Byte decode
  // ****************************************
  assign rx_byte = {sh[6:0], sda_s[1]};
  assign last_bit = bit_cnt == 4'h7;
  assign me = rx_byte[7:1] == SLAVE_ADDR;
  assign ara_hit = rx_byte[7:1] == `RTAM_ARA_ADDR && rx_byte[0] &&
                   alert_oe;
  assign lost = ara && (sda_s[1] == sda_oe);
  assign ara_done = state == ST_TX && scl_rise && last_bit && ara &&
                    !lost;
  assign wr_stb = state == ST_RX && scl_rise && last_bit && !first;

  // Read data selection
  assign status = {2'h0, rem_cr, rem_lo, rem_hi, loc_cr, loc_lo, loc_hi};
  assign rd_reg =
    (ptr == `RTAM_PTR_LOC) ? loc_val :
    (ptr == `RTAM_PTR_REM_HI) ? rem_val[10:3] :
    (ptr == `RTAM_PTR_REM_LO) ? {rem_val[2:0], 5'h00} :
    (ptr == `RTAM_PTR_STATUS) ? status :
    (ptr >= `RTAM_PTR_LIM && ptr < `RTAM_PTR_LIM + 8'(NLIM)) ?
      lim_w[3'(ptr - `RTAM_PTR_LIM)] :
    `RTAM_RD_UNMAPPED;
  assign rd_byte = ara ? {SLAVE_ADDR, 1'b0} : rd_reg;

  // ****************************************
  // Bus slave sequencer
  // ****************************************
  // Start wins over everything but reset; stop or timeout then frees the line
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      sh <= 8'h00;
      tx_sh <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      ack_on <= 1'b0;
      ara <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start) begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      ack_on <= 1'b0;
      ara <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop || tout_hit) begin
      state <= ST_IDLE;
      ack_on <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR: if (scl_rise) begin
          sh <= rx_byte;
          bit_cnt <= bit_cnt + 4'h1;
          if (last_bit) begin
            bit_cnt <= 4'h0;
            rw <= rx_byte[0];
            ara <= ara_hit;
            first <= 1'b1;
            state <= (me || ara_hit) ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: if (scl_fall) begin
          ack_on <= ~ack_on;
          if (!ack_on) begin
            sda_oe <= 1'b1;
          end else if (rw) begin
            tx_sh <= {rd_byte[6:0], 1'b0};
            sda_oe <= ~rd_byte[7];
            state <= ST_TX;
          end else begin
            sda_oe <= 1'b0;
            state <= ST_RX;
          end
        end
        ST_RX: if (scl_rise) begin
          sh <= rx_byte;
          bit_cnt <= bit_cnt + 4'h1;
          if (last_bit) begin
            bit_cnt <= 4'h0;
            first <= 1'b0;
            state <= ST_ACK;
            if (first) begin
              ptr <= rx_byte;
            end
          end
        end
        ST_TX: if (scl_fall) begin
          sda_oe <= ~tx_sh[7];
          tx_sh <= {tx_sh[6:0], 1'b0};
        end else if (scl_rise) begin
          bit_cnt <= bit_cnt + 4'h1;
          if (lost) begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end else if (last_bit) begin
            bit_cnt <= 4'h0;
            state <= ST_MACK;
          end
        end
        ST_MACK: if (scl_fall) begin
          sda_oe <= 1'b0;
        end else if (scl_rise) begin
          tx_sh <= rd_byte;
          state <= sda_s[1] ? ST_IDLE : ST_TX;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Limit registers
  // ****************************************
  for (genvar i = 0; i < NLIM; i++) begin : g_lim
    localparam logic [7:0] RST_V =
      (i == 2) ? `RTAM_LOC_CR_RST :
      (i == 5) ? `RTAM_REM_CR_RST :
      (i % 3 == 0) ? `RTAM_HI_RST : `RTAM_LO_RST;
    logic [7:0] val;
    always_ff @(posedge clk) begin
      if (rst) begin
        val <= RST_V;
      end else if (wr_stb && ptr == `RTAM_PTR_LIM + 8'(i)) begin
        val <= rx_byte;
      end
    end
    assign lim_w[i] = val;
  end

  // ****************************************
  // Comparators
  // ****************************************
  assign loc_hi = $signed(loc_val) > $signed(lim_w[0]);
  assign loc_lo = $signed(loc_val) < $signed(lim_w[1]);
  assign loc_cr = $signed(loc_val) > $signed(lim_w[2]);
  assign rem_hi = rem_val > $signed({lim_w[3], 3'h0});
  assign rem_lo = rem_val < $signed({lim_w[4], 3'h0});
  assign rem_cr = rem_val > $signed({lim_w[5], 3'h0});
  assign crit_any = loc_cr | rem_cr;
  assign out_win = loc_hi | loc_lo | rem_hi | rem_lo | crit_any;

  // ****************************************
  // Alarm outputs
  // ****************************************
  // Alert latches; an alert response releases it until all clear
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_oe <= 1'b0;
      armed <= 1'b1;
      critical_alarm_oe <= 1'b0;
    end else begin
      alert_oe <= !ara_done && (alert_oe || (out_win && armed));
      armed <= !ara_done && (armed || !out_win);
      critical_alarm_oe <= crit_any;
    end
  end

  // Open-drain drive values, low whenever enabled
  always_ff @(posedge clk) begin
    if (rst) begin
      {sda_o, alert_o, critical_alarm_out} <= 3'h0;
    end else begin
      {sda_o, alert_o, critical_alarm_out} <= 3'h0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rem_shift;
    link_new && !rem_ovf |=>
      ({rem_val[10], rem_val} + 12'h080) == $past(link_rem);
  endproperty
  a_rem_shift: assert property (p_rem_shift)
    else $error("remote reading not shifted by 16 C");

  property p_loc_plain;
    link_new |=> loc_val == $past(link_loc);
  endproperty
  a_loc_plain: assert property (p_loc_plain)
    else $error("local reading altered");

  property p_alert_set;
    out_win && armed && !ara_done |=> alert_oe;
  endproperty
  a_alert_set: assert property (p_alert_set)
    else $error("alert missed an out-of-window reading");

  property p_crit;
    ##1 critical_alarm_oe == $past(crit_any);
  endproperty
  a_crit: assert property (p_crit)
    else $error("critical alarm does not follow limit");

  property p_rem_fmt;
    ptr == `RTAM_PTR_REM_LO |->
      rd_reg[4:0] == 5'h00 && rd_reg[7:5] == rem_val[2:0];
  endproperty
  a_rem_fmt: assert property (p_rem_fmt)
    else $error("remote low byte badly formatted");

  property p_addr;
    state == ST_ADDR && scl_rise && last_bit && !me && !ara_hit &&
      !tout_hit |=> state == ST_IDLE ##1 !sda_oe;
  endproperty
  a_addr: assert property (p_addr)
    else $error("answered a foreign address");

  property p_tout;
    tout_hit |=> state == ST_IDLE && !sda_oe;
  endproperty
  a_tout: assert property (p_tout)
    else $error("timeout did not free the bus");

  property p_ara;
    ara_done |=> !alert_oe && !armed;
  endproperty
  a_ara: assert property (p_ara)
    else $error("alert not released after response");

  property p_od;
    !alert_o && !critical_alarm_out && !sda_o;
  endproperty
  a_od: assert property (p_od)
    else $error("open-drain pin driven high");

  property p_rem_lim;
    rem_val > $signed({lim_w[5], 3'h0}) |=> critical_alarm_oe;
  endproperty
  a_rem_lim: assert property (p_rem_lim)
    else $error("remote critical compare off scale");

  c_write: cover property (wr_stb);
  c_read: cover property (state == ST_MACK && scl_rise && sda_s[1]);
  c_ara: cover property (ara_done);
  c_tout: cover property (tout_hit);
endmodule // rtam_core

//--- tb/rtam_host_model.sv
// Bus host model for the temperature alarm monitor bench.
// Assumes a pull-up on the data line and a device that only pulls low.
`timescale 1ns/100ps
`include "rtam_map.svh"
module rtam_host_model (
  input wire logic clk, // Bench system clock
  input wire logic sda_oe, // Device pull-down enable
  output logic scl, // Bus clock, held high between frames
  output logic sda // Resolved data line level
);
  logic host_low;
  // ****************************************
  // Wire resolution and bit timing
  // ****************************************
  // Pull-up wins unless either party pulls low
  assign sda = (host_low || sda_oe) ? 1'b0 : 1'b1;
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
  end
  task hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Start or repeated start: data falls while clock is high
  task start();
    host_low = 1'b0;
    hold(5);
    scl = 1'b1;
    hold(10);
    host_low = 1'b1;
    hold(10);
    scl = 1'b0;
    hold(5);
  endtask
  // Stop: data rises while clock is high, clock then stands high
  task stop();
    host_low = 1'b1;
    hold(5);
    scl = 1'b1;
    hold(10);
    host_low = 1'b0;
    hold(10);
  endtask
  task bit_out(input logic b);
    host_low = !b;
    hold(5);
    scl = 1'b1;
    hold(10);
    scl = 1'b0;
    hold(5);
  endtask
  // Data is taken in the middle of the clock high phase
  task bit_in(output logic b);
    host_low = 1'b0;
    hold(5);
    scl = 1'b1;
    hold(5);
    b = sda;
    hold(5);
    scl = 1'b0;
    hold(5);
  endtask
  // ****************************************
  // Byte transfers, most significant bit first
  // ****************************************
  task send_byte(input logic [7:0] d, output logic ack);
    logic nack;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(nack);
    ack = !nack;
  endtask
  task recv_byte(input logic mack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(!mack);
  endtask
  // Alert response read: host names the response address, ends with NACK
  task alert_response(output logic ack, output logic [7:0] d);
    start();
    send_byte({`RTAM_ARA_ADDR, 1'b1}, ack);
    recv_byte(1'b0, d);
    stop();
  endtask
endmodule // rtam_host_model

//--- tb/testbench.sv
// Self-checking bench of the temperature alarm monitor core.
// Assumes rtam_pkg compiled first and pull-ups on all open-drain pins.
`timescale 1ns/100ps
module testbench;
  localparam logic [6:0] DEV_ADDR = 7'h2A; // Arbitrary bus address
  logic clk, rst, conv_clk, conv_valid, scl, sda, sda_o, sda_oe;
  logic alert_o, alert_oe, crit_o, crit_oe, a;
  logic [7:0] conv_loc, d;
  logic [11:0] conv_rem;
  int failures, total_checks;
  // Open-drain pins with pull-ups
  wire alert_pin = alert_oe ? 1'b0 : 1'b1;
  wire crit_pin = crit_oe ? 1'b0 : 1'b1;
  rtam_core #(.SLAVE_ADDR(DEV_ADDR), .TOUT_CYC(200), .TOUT_W(22)) dut (
    .clk(clk), .rst(rst), .conv_clk(conv_clk), .conv_valid(conv_valid),
    .conv_loc(conv_loc), .conv_rem(conv_rem), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o),
    .alert_oe(alert_oe), .critical_alarm_out(crit_o),
    .critical_alarm_oe(crit_oe));
  rtam_host_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  // ****************************************
  // Clocks, compare and closing
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  // Converter clock, 6 ns, phase unrelated to clk
  initial begin
    conv_clk = 1'b0;
    #1.3;
    forever #3 conv_clk = !conv_clk;
  end
  task check(input string name, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    complete_run();
  end
  // ****************************************
  // Stimulus tasks
  // ****************************************
  task sample(input logic [7:0] l, input logic [11:0] r);
    @(posedge conv_clk);
    #1;
    conv_loc = l;
    conv_rem = r;
    conv_valid = 1'b1;
    @(posedge conv_clk);
    #1;
    conv_valid = 1'b0;
    repeat (12) @(posedge clk);
    #1;
  endtask
  task wr(input logic [7:0] p, dat);
    host.start();
    host.send_byte({DEV_ADDR, 1'b0}, a);
    check("write ack", a, 1);
    host.send_byte(p, a);
    host.send_byte(dat, a);
    host.stop();
  endtask
  task rd(input string name, input logic [7:0] p, exp);
    host.start();
    host.send_byte({DEV_ADDR, 1'b0}, a);
    host.send_byte(p, a);
    host.start();
    host.send_byte({DEV_ADDR, 1'b1}, a);
    check("read ack", a, 1);
    host.recv_byte(1'b0, d);
    host.stop();
    check(name, d, exp);
  endtask
  task ara();
    host.alert_response(a, d);
    check("ara ack", a, 1);
    check("ara addr", d, {DEV_ADDR, 1'b0});
  endtask
  // Pin levels, and drive values that must never be high
  task pins(input logic al, cr);
    check("alert pin", alert_pin, al);
    check("crit pin", crit_pin, cr);
    check("drive values", {sda_o, alert_o, crit_o}, 8'h00);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset();
    logic [7:0] lim [6] = '{8'h46, 8'h00, 8'h55, 8'h46, 8'h00, 8'h6E};
    pins(1, 1);
    for (int i = 0; i < 6; i++) rd("limit reset", 8'(i + 4), lim[i]);
    rd("status reset", 8'h03, 8'h00);
  endtask
  task t_readings();
    sample(8'h19, 12'h193);
    rd("local", 8'h00, 8'h19);
    rd("remote hi", 8'h01, 8'h22);
    rd("remote lo", 8'h02, 8'h60);
    pins(1, 1);
  endtask
  task t_window();
    sample(8'h47, 12'h193);
    pins(0, 1);
    rd("status", 8'h03, 8'h01);
    ara();
    check("alert after ara", alert_pin, 1);
    sample(8'h47, 12'h193);
    check("alert stays clear", alert_pin, 1);
    sample(8'h19, 12'h193);
    sample(8'h19, 12'h000);
    check("alert remote low", alert_pin, 0);
    rd("neg hi", 8'h01, 8'hF0);
    rd("neg lo", 8'h02, 8'h00);
    ara();
  endtask
  task critical_limit();
    logic [7:0] l [4] = '{8'h55, 8'h56, 8'h19, 8'h19};
    logic [11:0] r [4] = '{12'h193, 12'h193, 12'h3F0, 12'h3F1};
    logic c [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    sample(8'h19, 12'h193);
    for (int i = 0; i < 4; i++) begin
      sample(l[i], r[i]);
      check("crit pin", crit_pin, c[i]);
    end
    check("alert on crit", alert_pin, 0);
    ara();
    sample(8'h19, 12'h193);
    pins(1, 1);
  endtask
  task t_limits();
    wr(8'h04, 8'h1E);
    rd("local high", 8'h04, 8'h1E);
    wr(8'h00, 8'h55);
    rd("read only", 8'h00, 8'h19);
    rd("unmapped", 8'h0A, 8'h00);
    sample(8'h1F, 12'h193);
    check("new high", alert_pin, 0);
    ara();
  endtask
  task t_addr_tout();
    host.start();
    host.send_byte({DEV_ADDR + 7'h01, 1'b0}, a);
    check("other addr ack", a, 0);
    host.stop();
    wr(8'h05, 8'h00);
    host.start();
    host.send_byte({DEV_ADDR, 1'b1}, a);
    host.bit_in(a);
    check("data bit", sda, 0);
    host.hold(250);
    check("timeout release", sda, 1);
    host.stop();
    rd("after timeout", 8'h05, 8'h00);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    conv_valid = 1'b0;
    conv_loc = 8'h00;
    conv_rem = 12'h000;
    failures = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    t_reset();
    t_readings();
    t_window();
    critical_limit();
    t_limits();
    t_addr_tout();
    complete_run();
  end
endmodule // testbench
